/* include/prcc_pkg.sv */
/*
 * shared constants, codes and carrier types of the power rail configuration command bank.
 * assumes a single 10 MHz system clock and command transactions already decoded from the
 * management bus into one-cycle requests.
 */
package prcc_pkg;

	// command codes of the bank
	localparam logic [7:0] CMD_LOOP_TUNING = 8'hdf;
	localparam logic [7:0] CMD_RAIL_SEQUENCING = 8'he0;
	localparam logic [7:0] CMD_BROADCAST_GROUP = 8'he2;
	localparam logic [7:0] CMD_IDENTIFIER_STRING = 8'he4;
	localparam logic [7:0] CMD_OVERCURRENT_RESPONSE = 8'he5;
	localparam logic [7:0] CMD_UNDERCURRENT_RESPONSE = 8'he6;
	localparam logic [7:0] CMD_SWITCH_CLOCK_SELECT = 8'he9;

	// answer lengths in bytes
	localparam logic [4:0] LEN_LOOP_TUNING = 5'h04;
	localparam logic [4:0] LEN_RAIL_SEQUENCING = 5'h02;
	localparam logic [4:0] LEN_BROADCAST_GROUP = 5'h03;
	localparam logic [4:0] LEN_IDENTIFIER_STRING = 5'h10;
	localparam logic [4:0] LEN_ONE_BYTE = 5'h01;

	// loop tuning field layout
	localparam int LOOP_ENABLE_BIT = 24;
	localparam int LOOP_RESIDUAL_LSB = 16;
	localparam int LOOP_GAIN_LSB = 0;
	localparam logic [31:0] LOOP_WRITE_MASK = 32'h01ff_ffff;

	// sequencing field layout
	localparam int SEQ_PREQUEL_EN_BIT = 15;
	localparam int SEQ_PREQUEL_ID_LSB = 8;
	localparam int SEQ_SEQUEL_EN_BIT = 7;
	localparam int SEQ_SEQUEL_ID_LSB = 0;
	localparam logic [15:0] SEQ_WRITE_MASK = 16'h9f9f;
	localparam logic [15:0] SEQ_RESET = 16'h0000;

	// broadcast group field layout
	localparam int GRP_VOLT_EN_BIT = 21;
	localparam int GRP_VOLT_ID_LSB = 16;
	localparam int GRP_OPER_EN_BIT = 13;
	localparam int GRP_OPER_ID_LSB = 8;
	localparam int GRP_FAIL_FAST_BIT = 5;
	localparam int GRP_FAIL_ID_LSB = 0;
	localparam logic [23:0] GRP_WRITE_MASK = 24'h3f_3f3f;
	localparam logic [23:0] GRP_STANDALONE = 24'h00_0000;
	localparam logic [23:0] GRP_SHARING = 24'h20_2000;

	// fault response codes
	localparam logic [7:0] RESP_OFF_NO_RETRY = 8'h80;
	localparam logic [7:0] RESP_OFF_RETRY = 8'hbf;
	localparam logic [7:0] RESP_RESET = 8'h80;

	// switching clock codes
	localparam logic [7:0] CLK_INTERNAL = 8'h00;
	localparam logic [7:0] CLK_INTERNAL_OUT = 8'h02;
	localparam logic [7:0] CLK_EXTERNAL = 8'h04;

	// output-current status bits
	localparam int IOUT_OC_BIT = 7;
	localparam int IOUT_UC_BIT = 4;

	// retry timing
	localparam int CLK_HZ = 10_000_000;
	localparam int RETRY_TIME_MS = 70;
	localparam int RETRY_CYCLES = RETRY_TIME_MS * (CLK_HZ / 1000);

	// arbitrary identifier text, not tied to any real part
	localparam logic [127:0] IDENT_DEFAULT = 128'h5052_4343_2d30_3030_312d_4130_2d46_3031;

	// inter-module event kinds
	typedef enum logic [2:0] {
		EV_NONE = 3'b000,
		EV_POWER_GOOD = 3'b001,
		EV_POWER_DOWN = 3'b010,
		EV_POWER_FAIL = 3'b011,
		EV_GROUP_VOLTAGE = 3'b100,
		EV_GROUP_OPERATION = 3'b101
	} prcc_event_kind_type;

	// one event on the inter-module event bus
	typedef struct packed {
		prcc_event_kind_type kind;
		logic [4:0] id;
		logic [15:0] data;
	} prcc_event_type;

	// one decoded host command
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [31:0] data;
	} prcc_cmd_type;

	// rail output states
	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_WAIT_PREQUEL = 2'b01,
		ST_ON = 2'b10,
		ST_RAMP_DOWN = 2'b11
	} prcc_rail_state_type;

endpackage

/* core/prcc_fault_retry.sv */
/*
 * fault latch with optional timed retry for one current fault source.
 * assumes fault and rearm are synchronous to sys_clk; retryCycles is at least one.
 */
`timescale 1ns/1ps
module prcc_fault_retry #(
	parameter int RETRY_CYCLES = prcc_pkg::RETRY_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic fault,
	input wire logic [7:0] response,
	input wire logic rearm,
	output logic faultOff
);

	// whole state of this module
	typedef struct packed {
		logic off;
		logic [19:0] count;
	} prcc_retry_state_type;

	prcc_retry_state_type s;
	prcc_retry_state_type next_s;

	// fault holds the rail off; the retry code counts down, the no-retry code waits for rearm
	always_comb begin
		next_s = s;
		if (fault) begin
			next_s.off = 1'b1;
			next_s.count = 20'(RETRY_CYCLES - 1);
		end else if (s.off) begin
			if (response == prcc_pkg::RESP_OFF_RETRY) begin
				// continuous retry after the delay
				if (s.count == 20'h00000) begin
					next_s.off = 1'b0;
				end else begin
					next_s.count = s.count - 20'h00001;
				end
			end else if (rearm) begin
				// no retry: stays off until the enable is withdrawn
				next_s.off = 1'b0;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign faultOff = s.off;

endmodule

/* core/prcc_top.sv */
/*
 * power rail configuration command bank: loop tuning, rail sequencing over the inter-module
 * event bus, broadcast group responses, current fault responses, identifier and clock select.
 * assumes host commands arrive already decoded as one-cycle requests, events on the
 * inter-module event bus arrive as one-cycle words, and all inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps
module prcc_top #(
	parameter int RETRY_CYCLES = prcc_pkg::RETRY_CYCLES
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire prcc_pkg::prcc_cmd_type hostCmd,
	input wire logic strapCurrentShare,
	input wire logic [24:0] strapLoopTuning,
	input wire logic [15:0] strapSequence,
	input wire logic [7:0] strapClockCode,
	input wire logic [4:0] railId,
	input wire logic enableMet,
	input wire logic outputGood,
	input wire logic rampDone,
	input wire logic overcurrentFault,
	input wire logic undercurrentFault,
	input wire logic ioutStatusClear,
	input wire prcc_pkg::prcc_event_type evtIn,
	output logic hostAck,
	output logic hostUnsupported,
	output logic [127:0] hostReadData,
	output logic [4:0] hostReadLength,
	output logic outputOn,
	output logic rampDownReq,
	output logic immediateOff,
	output logic groupVoltageStrobe,
	output logic [15:0] groupVoltage,
	output logic groupOperationStrobe,
	output logic [7:0] groupOperation,
	output prcc_pkg::prcc_event_type evtOut,
	output logic [7:0] ioutStatus,
	output logic clockExternal,
	output logic syncDriveOut,
	output logic loopTuningEnable,
	output logic [7:0] loopResidual,
	output logic [15:0] loopGain
);

	// whole state of the block
	typedef struct packed {
		logic strapDone;
		logic shareMode;
		logic [24:0] loopTuning;
		logic [15:0] sequencing;
		logic seqWritten;
		logic [23:0] group;
		logic [7:0] ocResponse;
		logic [7:0] ucResponse;
		logic [7:0] clockSelect;
		logic [7:0] iout;
		logic prequelGood;
		logic goodSent;
		prcc_pkg::prcc_rail_state_type rail;
		logic ack;
		logic unsupported;
		logic [127:0] readData;
		logic [4:0] readLength;
		logic outputOn;
		logic rampDownReq;
		logic immediateOff;
		logic voltStrobe;
		logic [15:0] voltValue;
		logic operStrobe;
		logic [7:0] operValue;
		prcc_pkg::prcc_event_type evtOut;
	} prcc_state_type;

	prcc_state_type s;
	prcc_state_type next_s;

	logic ocOff; // overcurrent holds the rail off
	logic ucOff; // undercurrent holds the rail off
	logic faultOff; // any current fault holds the rail off
	logic [15:0] seqEff; // sequencing in force
	logic prequelOn; // prequel ordering active
	logic sequelOn; // sequel ordering active
	logic [4:0] prequelId; // rail id we wait for
	logic [4:0] sequelId; // rail id whose power-down ends us
	logic sequelDown; // sequel rail reported power-down this cycle
	logic failMatch; // power-fail for our group this cycle

	// overcurrent fault latch and retry timer
	prcc_fault_retry #(
		.RETRY_CYCLES(RETRY_CYCLES)
	) ocRetry (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.fault(overcurrentFault),
		.response(s.ocResponse),
		.rearm(!enableMet),
		.faultOff(ocOff)
	);

	// undercurrent fault latch and retry timer
	prcc_fault_retry #(
		.RETRY_CYCLES(RETRY_CYCLES)
	) ucRetry (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.fault(undercurrentFault),
		.response(s.ucResponse),
		.rearm(!enableMet),
		.faultOff(ucOff)
	);

	assign faultOff = ocOff | ucOff;

	// a host write wins over the strap choice once made
	assign seqEff = s.seqWritten ? s.sequencing : strapSequence;
	assign prequelOn = seqEff[prcc_pkg::SEQ_PREQUEL_EN_BIT];
	assign sequelOn = seqEff[prcc_pkg::SEQ_SEQUEL_EN_BIT];
	assign prequelId = seqEff[prcc_pkg::SEQ_PREQUEL_ID_LSB +: 5];
	assign sequelId = seqEff[prcc_pkg::SEQ_SEQUEL_ID_LSB +: 5];

	// event matches that steer the rail state
	always_comb begin
		sequelDown = sequelOn && evtIn.kind == prcc_pkg::EV_POWER_DOWN && evtIn.id == sequelId;
		failMatch = s.shareMode && evtIn.kind == prcc_pkg::EV_POWER_FAIL &&
			evtIn.id == s.group[prcc_pkg::GRP_FAIL_ID_LSB +: 5];
	end

	// next state: strap load, host commands, events, status and rail sequencing
	always_comb begin
		next_s = s;
		// one-cycle outputs fall back each cycle
		next_s.ack = 1'b0;
		next_s.unsupported = 1'b0;
		next_s.voltStrobe = 1'b0;
		next_s.operStrobe = 1'b0;
		next_s.immediateOff = 1'b0;
		next_s.evtOut = '0;

		// first cycle after reset: take defaults from the straps
		if (!s.strapDone) begin
			next_s.strapDone = 1'b1;
			next_s.shareMode = strapCurrentShare;
			next_s.loopTuning = strapLoopTuning;
			next_s.group = strapCurrentShare ? prcc_pkg::GRP_SHARING : prcc_pkg::GRP_STANDALONE;
			if (strapClockCode == prcc_pkg::CLK_INTERNAL_OUT || strapClockCode == prcc_pkg::CLK_EXTERNAL) begin
				next_s.clockSelect = strapClockCode;
			end else begin
				next_s.clockSelect = prcc_pkg::CLK_INTERNAL;
			end
		end

		// host command handling
		if (hostCmd.valid) begin
			next_s.ack = 1'b1;
			next_s.readData = '0;
			next_s.readLength = '0;
			case (hostCmd.code)
				prcc_pkg::CMD_LOOP_TUNING: begin
					// reserved upper bits dropped on write, read as zero
					if (hostCmd.write) begin
						next_s.loopTuning = 25'(hostCmd.data & prcc_pkg::LOOP_WRITE_MASK);
					end else begin
						next_s.readData = {103'h0, s.loopTuning};
						next_s.readLength = prcc_pkg::LEN_LOOP_TUNING;
					end
				end
				prcc_pkg::CMD_RAIL_SEQUENCING: begin
					if (hostCmd.write) begin
						next_s.sequencing = hostCmd.data[15:0] & prcc_pkg::SEQ_WRITE_MASK;
						next_s.seqWritten = 1'b1;
					end else begin
						next_s.readData = {112'h0, s.sequencing};
						next_s.readLength = prcc_pkg::LEN_RAIL_SEQUENCING;
					end
				end
				prcc_pkg::CMD_BROADCAST_GROUP: begin
					if (hostCmd.write) begin
						next_s.group = hostCmd.data[23:0] & prcc_pkg::GRP_WRITE_MASK;
					end else begin
						next_s.readData = {104'h0, s.group};
						next_s.readLength = prcc_pkg::LEN_BROADCAST_GROUP;
					end
				end
				prcc_pkg::CMD_IDENTIFIER_STRING: begin
					// read-only: a write is refused
					if (hostCmd.write) begin
						next_s.unsupported = 1'b1;
					end else begin
						next_s.readData = prcc_pkg::IDENT_DEFAULT;
						next_s.readLength = prcc_pkg::LEN_IDENTIFIER_STRING;
					end
				end
				prcc_pkg::CMD_OVERCURRENT_RESPONSE: begin
					if (hostCmd.write) begin
						// only the two defined codes are taken
						if (hostCmd.data[7:0] == prcc_pkg::RESP_OFF_NO_RETRY ||
							hostCmd.data[7:0] == prcc_pkg::RESP_OFF_RETRY) begin
							next_s.ocResponse = hostCmd.data[7:0];
						end else begin
							next_s.unsupported = 1'b1;
						end
					end else begin
						next_s.readData = {120'h0, s.ocResponse};
						next_s.readLength = prcc_pkg::LEN_ONE_BYTE;
					end
				end
				prcc_pkg::CMD_UNDERCURRENT_RESPONSE: begin
					if (hostCmd.write) begin
						// same two codes as the overcurrent side
						if (hostCmd.data[7:0] == prcc_pkg::RESP_OFF_NO_RETRY ||
							hostCmd.data[7:0] == prcc_pkg::RESP_OFF_RETRY) begin
							next_s.ucResponse = hostCmd.data[7:0];
						end else begin
							next_s.unsupported = 1'b1;
						end
					end else begin
						next_s.readData = {120'h0, s.ucResponse};
						next_s.readLength = prcc_pkg::LEN_ONE_BYTE;
					end
				end
				prcc_pkg::CMD_SWITCH_CLOCK_SELECT: begin
					if (hostCmd.write) begin
						// codes other than the three sources are refused
						if (hostCmd.data[7:0] == prcc_pkg::CLK_INTERNAL ||
							hostCmd.data[7:0] == prcc_pkg::CLK_INTERNAL_OUT ||
							hostCmd.data[7:0] == prcc_pkg::CLK_EXTERNAL) begin
							next_s.clockSelect = hostCmd.data[7:0];
						end else begin
							next_s.unsupported = 1'b1;
						end
					end else begin
						next_s.readData = {120'h0, s.clockSelect};
						next_s.readLength = prcc_pkg::LEN_ONE_BYTE;
					end
				end
				default: begin
					// code outside this bank
					next_s.unsupported = 1'b1;
				end
			endcase
		end

		// prequel power-good memory, tracked whether or not we are waiting yet
		if (evtIn.kind == prcc_pkg::EV_POWER_GOOD && evtIn.id == prequelId) begin
			next_s.prequelGood = 1'b1;
		end else if (evtIn.kind == prcc_pkg::EV_POWER_DOWN && evtIn.id == prequelId) begin
			next_s.prequelGood = 1'b0;
		end

		// group broadcasts gated by enable bit and id
		if (evtIn.kind == prcc_pkg::EV_GROUP_VOLTAGE && s.group[prcc_pkg::GRP_VOLT_EN_BIT] &&
			evtIn.id == s.group[prcc_pkg::GRP_VOLT_ID_LSB +: 5]) begin
			next_s.voltStrobe = 1'b1;
			next_s.voltValue = evtIn.data;
		end
		if (evtIn.kind == prcc_pkg::EV_GROUP_OPERATION && s.group[prcc_pkg::GRP_OPER_EN_BIT] &&
			evtIn.id == s.group[prcc_pkg::GRP_OPER_ID_LSB +: 5]) begin
			next_s.operStrobe = 1'b1;
			next_s.operValue = evtIn.data[7:0];
		end

		// status flags: a fault in the clear cycle still sets
		next_s.iout[prcc_pkg::IOUT_OC_BIT] = (s.iout[prcc_pkg::IOUT_OC_BIT] & ~ioutStatusClear) | overcurrentFault;
		next_s.iout[prcc_pkg::IOUT_UC_BIT] = (s.iout[prcc_pkg::IOUT_UC_BIT] & ~ioutStatusClear) | undercurrentFault;

		// rail output state machine
		case (s.rail)
			prcc_pkg::ST_OFF: begin
				if (enableMet && !faultOff && !overcurrentFault && !undercurrentFault) begin
					if (prequelOn && !next_s.prequelGood) begin
						next_s.rail = prcc_pkg::ST_WAIT_PREQUEL;
					end else begin
						next_s.rail = prcc_pkg::ST_ON;
					end
				end
			end
			prcc_pkg::ST_WAIT_PREQUEL: begin
				// both own enable and prequel power-good needed
				if (!enableMet || faultOff) begin
					next_s.rail = prcc_pkg::ST_OFF;
				end else if (!prequelOn || next_s.prequelGood) begin
					next_s.rail = prcc_pkg::ST_ON;
				end
			end
			prcc_pkg::ST_ON: begin
				if (overcurrentFault || undercurrentFault || (failMatch && s.group[prcc_pkg::GRP_FAIL_FAST_BIT])) begin
					// fault or fast power-fail: off at once
					next_s.rail = prcc_pkg::ST_OFF;
					next_s.immediateOff = 1'b1;
				end else if (failMatch || sequelDown || !enableMet) begin
					// sequenced shutdown through the programmed delays
					next_s.rail = prcc_pkg::ST_RAMP_DOWN;
				end else if (outputGood && !s.goodSent) begin
					// announce our power-good under our own rail id
					next_s.goodSent = 1'b1;
					next_s.evtOut.kind = prcc_pkg::EV_POWER_GOOD;
					next_s.evtOut.id = railId;
				end
			end
			prcc_pkg::ST_RAMP_DOWN: begin
				if (overcurrentFault || undercurrentFault || (failMatch && s.group[prcc_pkg::GRP_FAIL_FAST_BIT])) begin
					next_s.rail = prcc_pkg::ST_OFF;
					next_s.immediateOff = 1'b1;
				end else if (rampDone) begin
					next_s.rail = prcc_pkg::ST_OFF;
				end
			end
			default: begin
				next_s.rail = prcc_pkg::ST_OFF;
			end
		endcase

		// on reaching off, announce power-down under our rail id
		if (s.rail != prcc_pkg::ST_OFF && next_s.rail == prcc_pkg::ST_OFF) begin
			next_s.goodSent = 1'b0;
			next_s.evtOut.kind = prcc_pkg::EV_POWER_DOWN;
			next_s.evtOut.id = railId;
			next_s.evtOut.data = '0;
		end
		next_s.outputOn = next_s.rail == prcc_pkg::ST_ON || next_s.rail == prcc_pkg::ST_RAMP_DOWN;
		next_s.rampDownReq = next_s.rail == prcc_pkg::ST_RAMP_DOWN;
	end

	// state register; constants only under reset
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.sequencing <= prcc_pkg::SEQ_RESET;
			s.ocResponse <= prcc_pkg::RESP_RESET;
			s.ucResponse <= prcc_pkg::RESP_RESET;
			s.rail <= prcc_pkg::ST_OFF;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from the state register
	assign hostAck = s.ack;
	assign hostUnsupported = s.unsupported;
	assign hostReadData = s.readData;
	assign hostReadLength = s.readLength;
	assign outputOn = s.outputOn;
	assign rampDownReq = s.rampDownReq;
	assign immediateOff = s.immediateOff;
	assign groupVoltageStrobe = s.voltStrobe;
	assign groupVoltage = s.voltValue;
	assign groupOperationStrobe = s.operStrobe;
	assign groupOperation = s.operValue;
	assign evtOut = s.evtOut;
	assign ioutStatus = s.iout;
	assign clockExternal = s.clockSelect[2]; // only 04h sets bit 2
	assign syncDriveOut = s.clockSelect[1]; // only 02h sets bit 1
	assign loopTuningEnable = s.loopTuning[prcc_pkg::LOOP_ENABLE_BIT];
	assign loopResidual = s.loopTuning[prcc_pkg::LOOP_RESIDUAL_LSB +: 8];
	assign loopGain = s.loopTuning[prcc_pkg::LOOP_GAIN_LSB +: 16];

endmodule

/* tb/prcc_chk.sv */
/* checker: port timing of the power rail command bank.
   assumes one sys_clk domain, bound onto prcc_top. */
`timescale 1ns/1ps
module prcc_chk (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire prcc_pkg::prcc_cmd_type hostCmd,
	input wire logic [4:0] railId,
	input wire logic enableMet,
	input wire logic overcurrentFault,
	input wire logic undercurrentFault,
	input wire prcc_pkg::prcc_event_type evtIn,
	input wire logic hostAck,
	input wire logic hostUnsupported,
	input wire logic [127:0] hostReadData,
	input wire logic [4:0] hostReadLength,
	input wire logic outputOn,
	input wire logic immediateOff,
	input wire logic groupVoltageStrobe,
	input wire logic [15:0] groupVoltage,
	input wire logic groupOperationStrobe,
	input wire logic [7:0] groupOperation,
	input wire prcc_pkg::prcc_event_type evtOut,
	input wire logic [7:0] ioutStatus,
	input wire logic clockExternal,
	input wire logic syncDriveOut
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	prcc_pkg::prcc_cmd_type lastCmd; // command of the previous edge
	prcc_pkg::prcc_event_type lastEvt; // event of the previous edge
	// keep last request words for the answer checks
	always_ff @(posedge sys_clk) begin
		lastCmd <= hostCmd;
		lastEvt <= evtIn;
	end
	wire logic wrCmd = hostCmd.valid && hostCmd.write;
	wire logic rdCmd = hostCmd.valid && !hostCmd.write;
	property p_ack; hostCmd.valid |=> hostAck; endproperty
	a_ack: assert property (p_ack) else $error("no answer to command");
	property p_clock; wrCmd && hostCmd.code == 8'he9 && hostCmd.data[7:0] inside {8'h00, 8'h02, 8'h04}
		|=> clockExternal == (lastCmd.data[7:0] == 8'h04) && syncDriveOut == (lastCmd.data[7:0] == 8'h02); endproperty
	a_clock: assert property (p_clock) else $error("clock source wrong");
	property p_refuse; wrCmd && (hostCmd.code == 8'he4 || (hostCmd.code inside {8'he5, 8'he6}
		&& !(hostCmd.data[7:0] inside {8'h80, 8'hbf}))) |=> hostUnsupported && hostReadLength == 5'h00; endproperty
	a_refuse: assert property (p_refuse) else $error("bad write taken");
	property p_ident; rdCmd && hostCmd.code == 8'he4
		|=> hostReadLength == 5'h10 && hostReadData == prcc_pkg::IDENT_DEFAULT; endproperty
	a_ident: assert property (p_ident) else $error("identifier read wrong");
	property p_seqrd; rdCmd && hostCmd.code == 8'he0
		|=> hostReadLength == 5'h02 && hostReadData[127:16] == 112'h0 && hostReadData[14:13] == 2'h0; endproperty
	a_seqrd: assert property (p_seqrd) else $error("sequencing read wrong");
	property p_oc; overcurrentFault |=> ioutStatus[7]; endproperty
	a_oc: assert property (p_oc) else $error("overcurrent flag missing");
	property p_uc; undercurrentFault |=> ioutStatus[4]; endproperty
	a_uc: assert property (p_uc) else $error("undercurrent flag missing");
	property p_trip; (overcurrentFault || undercurrentFault) && outputOn |=> !outputOn && immediateOff; endproperty
	a_trip: assert property (p_trip) else $error("fault left output on");
	property p_gv; groupVoltageStrobe |-> lastEvt.kind == prcc_pkg::EV_GROUP_VOLTAGE && groupVoltage == lastEvt.data;
	endproperty
	a_gv: assert property (p_gv) else $error("group voltage without event");
	property p_go; groupOperationStrobe
		|-> lastEvt.kind == prcc_pkg::EV_GROUP_OPERATION && groupOperation == lastEvt.data[7:0]; endproperty
	a_go: assert property (p_go) else $error("group operation without event");
	property p_start; $rose(outputOn) |-> $past(enableMet); endproperty
	a_start: assert property (p_start) else $error("output on without enable");
	property p_ownid; evtOut.kind inside {prcc_pkg::EV_POWER_GOOD, prcc_pkg::EV_POWER_DOWN} |-> evtOut.id == railId;
	endproperty
	a_ownid: assert property (p_ownid) else $error("event carries wrong rail");
	c_good: cover property (evtOut.kind == prcc_pkg::EV_POWER_GOOD);
	c_fast: cover property (immediateOff);
	c_gv: cover property (groupVoltageStrobe);
endmodule
bind prcc_top prcc_chk u_chk (.sys_clk, .reset_n, .hostCmd, .railId, .enableMet, .overcurrentFault,
	.undercurrentFault, .evtIn, .hostAck, .hostUnsupported, .hostReadData, .hostReadLength, .outputOn,
	.immediateOff, .groupVoltageStrobe, .groupVoltage, .groupOperationStrobe, .groupOperation, .evtOut,
	.ioutStatus, .clockExternal, .syncDriveOut);

/* tb/prcc_peer_model.sv */
/* peer rails and output stage: sends event words, answers power-good and ramp done.
   assumes send is called from the bench just after a clock edge. */
`timescale 1ns/1ps
module prcc_peer_model #(
	parameter int GOOD_DELAY = 3,
	parameter int DOWN_DELAY = 4
) (
	input wire logic sys_clk,
	input wire logic outputOn,
	input wire logic rampDownReq,
	output logic outputGood,
	output logic rampDone,
	output prcc_pkg::prcc_event_type evtIn
);
	int goodCnt = 0; // cycles the output has been on
	int downCnt = 0; // cycles the ramp-down has run
	initial evtIn = '0;
	// output settles, then the ramp-down needs its programmed delays
	always @(posedge sys_clk) begin
		goodCnt <= outputOn ? goodCnt + 1 : 0;
		downCnt <= rampDownReq ? downCnt + 1 : 0;
	end
	assign outputGood = outputOn && goodCnt >= GOOD_DELAY;
	assign rampDone = rampDownReq && downCnt >= DOWN_DELAY;
	// one event word for one cycle, idle otherwise
	task automatic send(input prcc_pkg::prcc_event_kind_type kind, input logic [4:0] id, input logic [15:0] data);
		@(posedge sys_clk) #1 evtIn = '{kind, id, data};
		@(posedge sys_clk) #1 evtIn = '0;
	endtask
endmodule

/* tb/tb.sv */
/* bench: host command tasks, sequencing, group events and current faults.
   assumes a short retry count and the peer model on the event side. */
`timescale 1ns/1ps
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin mismatches++; $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module tb;
	localparam int RETRY = 20; // shortened retry span
	logic sys_clk = 0;
	logic reset_n = 0;
	prcc_pkg::prcc_cmd_type hostCmd = '0;
	logic strapCurrentShare = 1'b1; // sharing strap: power-fail listened to
	logic [24:0] strapLoopTuning = 25'h12a0032;
	logic [15:0] strapSequence = 16'h8500; // strap prequel on rail 5
	logic [7:0] strapClockCode = 8'h04;
	logic [4:0] railId = 5'h09;
	logic enableMet = 0, overcurrentFault = 0, undercurrentFault = 0, ioutStatusClear = 0, outputGood, rampDone;
	logic hostAck, hostUnsupported, outputOn, rampDownReq, immediateOff, groupVoltageStrobe, groupOperationStrobe;
	logic clockExternal, syncDriveOut, loopTuningEnable, uns;
	logic [127:0] hostReadData, rd;
	logic [4:0] hostReadLength, len;
	logic [15:0] groupVoltage, loopGain;
	logic [7:0] groupOperation, ioutStatus, loopResidual;
	prcc_pkg::prcc_event_type evtIn, evtOut;
	int mismatches = 0, nCompared = 0, n;
	always #50 sys_clk = ~sys_clk;
	prcc_top #(.RETRY_CYCLES(RETRY)) DUT (.sys_clk, .reset_n, .hostCmd, .strapCurrentShare, .strapLoopTuning,
		.strapSequence, .strapClockCode, .railId, .enableMet, .outputGood, .rampDone, .overcurrentFault,
		.undercurrentFault, .ioutStatusClear, .evtIn, .hostAck, .hostUnsupported, .hostReadData, .hostReadLength,
		.outputOn, .rampDownReq, .immediateOff, .groupVoltageStrobe, .groupVoltage, .groupOperationStrobe,
		.groupOperation, .evtOut, .ioutStatus, .clockExternal, .syncDriveOut, .loopTuningEnable, .loopResidual,
		.loopGain);
	prcc_peer_model peer (.sys_clk, .outputOn, .rampDownReq, .outputGood, .rampDone, .evtIn);
	// one command for one cycle; the answer stands just after the taking edge
	task automatic xfer(input logic w, input logic [7:0] c, input logic [31:0] d);
		@(posedge sys_clk) #1 hostCmd = '{1'b1, w, c, d};
		@(posedge sys_clk) #1 hostCmd = '0;
		rd = hostReadData;
		len = hostReadLength;
		uns = hostUnsupported;
	endtask
	task automatic rdChk(input logic [7:0] c, input logic [127:0] e, input logic [4:0] l);
		xfer(1'b0, c, 32'h0);
		`CHK(rd, e)
		`CHK(len, l)
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d, input logic refuse);
		xfer(1'b1, c, d);
		`CHK(uns, refuse)
	endtask
	// bounded wait for the output level, counting cycles
	task automatic waitOn(input logic lvl, input int lim);
		n = 0;
		while (outputOn !== lvl && n < lim) begin
			@(posedge sys_clk) #1 n++;
		end
	endtask
	task automatic printVerdict();
		if (mismatches == 0 && nCompared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// watchdog
	initial begin
		#(5000 * 100);
		mismatches++;
		printVerdict();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1;
		repeat (2) @(posedge sys_clk);
		rdChk(8'he0, 128'h0, 5'h02);
		rdChk(8'he5, 128'h80, 5'h01);
		rdChk(8'he6, 128'h80, 5'h01);
		rdChk(8'hdf, {103'h0, strapLoopTuning}, 5'h04);
		rdChk(8'he9, 128'h04, 5'h01);
		`CHK(clockExternal, 1'b1)
		rdChk(8'he2, {104'h0, prcc_pkg::GRP_SHARING}, 5'h03);
		wr(8'hdf, 32'hffff_ffff, 1'b0);
		rdChk(8'hdf, 128'h01ff_ffff, 5'h04);
		wr(8'hdf, 32'h0133_1234, 1'b0);
		`CHK({loopTuningEnable, loopResidual, loopGain}, 25'h1331234)
		wr(8'he0, 32'h0000_ffff, 1'b0);
		rdChk(8'he0, 128'h9f9f, 5'h02);
		rdChk(8'he4, prcc_pkg::IDENT_DEFAULT, 5'h10);
		wr(8'he4, 32'h0, 1'b1);
		wr(8'he1, 32'h0, 1'b1);
		for (int i = 0; i < 3; i++) begin
			wr(8'he9, 32'(i * 2), 1'b0);
			`CHK({clockExternal, syncDriveOut}, {i == 2, i == 1})
		end
		wr(8'he9, 32'h0000_0003, 1'b1);
		wr(8'he5, 32'h0000_0081, 1'b1);
		wr(8'he6, 32'h0000_00bf, 1'b0);
		wr(8'he6, 32'h0000_0080, 1'b0);
		wr(8'he5, 32'h0000_00bf, 1'b0);
		rdChk(8'he5, 128'hbf, 5'h01);
		wr(8'he0, 32'h0000_8183, 1'b0);
		enableMet = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1 `CHK(outputOn, 1'b0)
		peer.send(prcc_pkg::EV_POWER_GOOD, 5'h05, 16'h0000);
		`CHK(outputOn, 1'b0)
		peer.send(prcc_pkg::EV_POWER_GOOD, 5'h01, 16'h0000);
		`CHK(outputOn, 1'b1)
		repeat (6) @(posedge sys_clk);
		peer.send(prcc_pkg::EV_POWER_DOWN, 5'h03, 16'h0000);
		`CHK({outputOn, rampDownReq}, 2'b11)
		wr(8'he0, 32'h0, 1'b0);
		waitOn(1'b0, 20);
		`CHK(outputOn, 1'b0)
		waitOn(1'b1, 10);
		wr(8'he2, 32'h0025_2a21, 1'b0);
		peer.send(prcc_pkg::EV_GROUP_VOLTAGE, 5'h05, 16'h1234);
		`CHK({groupVoltageStrobe, groupVoltage}, {1'b1, 16'h1234})
		peer.send(prcc_pkg::EV_GROUP_VOLTAGE, 5'h06, 16'h5555);
		`CHK({groupVoltageStrobe, groupVoltage}, {1'b0, 16'h1234})
		peer.send(prcc_pkg::EV_GROUP_OPERATION, 5'h0a, 16'h00a5);
		`CHK({groupOperationStrobe, groupOperation}, {1'b1, 8'ha5})
		wr(8'he2, 32'h0005_0a21, 1'b0);
		peer.send(prcc_pkg::EV_GROUP_OPERATION, 5'h0a, 16'h0033);
		`CHK(groupOperationStrobe, 1'b0)
		peer.send(prcc_pkg::EV_GROUP_VOLTAGE, 5'h05, 16'h0077);
		`CHK(groupVoltageStrobe, 1'b0)
		peer.send(prcc_pkg::EV_POWER_FAIL, 5'h01, 16'h0000);
		`CHK({outputOn, immediateOff}, 2'b01)
		waitOn(1'b1, 10);
		wr(8'he2, 32'h0000_0001, 1'b0);
		peer.send(prcc_pkg::EV_POWER_FAIL, 5'h01, 16'h0000);
		`CHK({outputOn, rampDownReq, immediateOff}, 3'b110)
		waitOn(1'b0, 20);
		waitOn(1'b1, 10);
		@(posedge sys_clk) #1 overcurrentFault = 1'b1;
		@(posedge sys_clk) #1 overcurrentFault = 1'b0;
		`CHK({ioutStatus, outputOn}, {8'h80, 1'b0})
		waitOn(1'b1, 2 * RETRY);
		`CHK({n >= RETRY - 1, outputOn}, 2'b11)
		@(posedge sys_clk) #1 ioutStatusClear = 1'b1;
		@(posedge sys_clk) #1 ioutStatusClear = 1'b0;
		undercurrentFault = 1'b1;
		@(posedge sys_clk) #1 undercurrentFault = 1'b0;
		`CHK({ioutStatus, outputOn}, {8'h10, 1'b0})
		waitOn(1'b1, 2 * RETRY);
		`CHK(outputOn, 1'b0)
		enableMet = 1'b0;
		@(posedge sys_clk) #1 enableMet = 1'b1;
		waitOn(1'b1, 10);
		`CHK(outputOn, 1'b1)
		strapCurrentShare = 1'b0;
		reset_n = 1'b0;
		@(posedge sys_clk) #1 reset_n = 1'b1;
		repeat (2) @(posedge sys_clk);
		rdChk(8'he2, 128'h0, 5'h03);
		`CHK(outputOn, 1'b0)
		peer.send(prcc_pkg::EV_POWER_GOOD, 5'h05, 16'h0);
		`CHK(outputOn, 1'b1)
		printVerdict();
	end
endmodule
